//--- core/adc_cfg_pkg.sv
// shared constants for the output pattern and offset configuration registers
package adc_cfg_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  REG2_OFF        = 8'h02;
    localparam logic [7:0]  REG3_OFF        = 8'h03;
    localparam logic [7:0]  REG4_OFF        = 8'h04;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    // register 2 writable image (all 16 bits, the pattern selectors and low delay bits among them)
    localparam logic [15:0] REG2_MASK       = 16'hFFFF;
    // register 3 fields
    localparam int          R3_SER_LSB      = 13;
    localparam int          R3_GAIN_BIT     = 12;
    localparam int          R3_DLY_LSB      = 9;
    localparam int          R3_OFS_BIT      = 8;
    localparam int          R3_WRSEL_BIT    = 5;
    // register 2 fields
    localparam int          R2_FCLK_LSB     = 13;
    localparam int          R2_DATA_LSB     = 7;
    localparam int          R2_DLY_LSB      = 0;
    // register 4 fields
    localparam int          R4_SELF_BIT     = 15;
    localparam int          R4_SSEL_BIT     = 14;
    localparam int          R4_MAN_BIT      = 13;
    localparam int          R4_ACC_LSB      = 9;
    localparam int          R4_IND_BIT      = 8;
    localparam int          R4_PSYNC_BIT    = 7;
    localparam int          R4_PMODE_BIT    = 6;
    localparam int          R4_PEN_BIT      = 5;
    localparam int          R4_MSB_BIT      = 4;
    localparam int          R4_RES_LSB      = 0;

    typedef enum logic [2:0] {
        PAT_NORMAL = 3'h0,
        PAT_SYNC   = 3'h1,
        PAT_DESKEW = 3'h2,
        PAT_CUSTOM = 3'h3,
        PAT_ONES   = 3'h4,
        PAT_TOGGLE = 3'h5,
        PAT_ZEROS  = 3'h6,
        PAT_RAMP   = 3'h7
    } pattern_t;

    localparam logic [2:0]  SER_12X         = 3'h0;
    localparam logic [2:0]  SER_14X         = 3'h1;
    localparam logic [2:0]  SER_16X         = 3'h4;
    localparam logic [2:0]  SER_10X         = 3'h3;
    localparam logic [1:0]  RES_12          = 2'h0;
    localparam logic [1:0]  RES_14          = 2'h1;
    localparam logic [1:0]  RES_10          = 2'h3;
    localparam logic [4:0]  BITS_10         = 5'h0A;
    localparam logic [4:0]  BITS_12         = 5'h0C;
    localparam logic [4:0]  BITS_14         = 5'h0E;
    localparam logic [4:0]  BITS_16         = 5'h10;
    localparam logic [4:0]  PRBS_LEN_23     = 5'h17;
    localparam logic [4:0]  PRBS_LEN_9      = 5'h09;
endpackage

//--- core/adc_output_pattern_config_regs.sv
// configuration bank for the serialized output path, patterns and offset-correction start
`timescale 1ns/1ps
// Function
// - both pattern selectors share one code: 000 normal, 100 ones, 110 zeros
// - 001 sync half ones half zeros, 010 deskew, 011 custom, 101 toggle, 111 ramp
// - serialization code 000 gives 12, 001 gives 14, 100 gives 16, 011 gives 10
// - register 3 bit 12 enables digital gain, zero bypasses it
// - 8-bit trigger delay: top two from register 3 bits 10-9, rest register 2 bits 5-0
// - after a trigger pulse wait delay samples before starting offset correction
// - register 3 bit 8 enables digital offset subtraction
// - register 4 low byte: hold-reset, length, enable, msb-first, zeros, resolution
// - every field of registers 3 and 4 is read/write and resets to zero
// - resolution 00 twelve bits, 01 fourteen, 11 ten, 10 unused
// - bit-order one sends msb first, zero sends lsb first
// - prbs length zero selects 23-bit generator, one selects 9-bit
// - start select one starts on trigger pin, zero on manual start bit
module adc_output_pattern_config_regs #(
    parameter int ADDR_W = adc_cfg_pkg::ADDR_W,
    parameter int DATA_W = adc_cfg_pkg::DATA_W
) (
    // clock, reset, enable
    input  wire logic              CORE_CLK_I,
    input  wire logic              NRST_I,
    input  wire logic              CLK_EN_I,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [DATA_W-1:0] RDATA_O,
    // sample timing and trigger pin
    input  wire logic              SAMPLE_TICK_I,
    input  wire logic              TRIGGER_PIN_I,
    // decoded configuration
    output logic      [2:0]        DATA_PATTERN_O,
    output logic      [2:0]        FCLK_PATTERN_O,
    output logic      [4:0]        SER_BITS_O,
    output logic                   SER_CODE_BAD_O,
    output logic      [4:0]        RES_BITS_O,
    output logic                   RES_CODE_BAD_O,
    output logic                   DIGITAL_GAIN_ENABLE_O,
    output logic                   DIG_OFS_EN_O,
    output logic                   LINK_WR_SEL_O,
    output logic                   PRBS_GENERATOR_ENABLE_O,
    output logic                   PRBS_HOLD_O,
    output logic      [4:0]        PRBS_LEN_O,
    output logic                   PRBS_ALLOWED_O,
    output logic                   MSB_FIRST_O,
    output logic                   IND_PATTERNS_O,
    output logic                   AUTO_OFS_EN_O,
    output logic      [3:0]        ACC_SAMPLES_O,
    output logic                   DATA_SYNC_WORD_O,
    output logic                   OFS_START_O,
    output logic                   OFS_WAIT_O
);
    // register images
    logic [15:0] reg2_r, reg2_nxt;
    logic [15:0] reg3_r, reg3_nxt;
    logic [15:0] reg4_r, reg4_nxt;
    logic [15:0] rdata_nxt;

    // pin synchroniser and offset-start sequencing
    logic        trig_s1_r, trig_s2_r, trig_s3_r;
    logic        trig_s1_nxt, trig_s2_nxt, trig_s3_nxt;
    logic [7:0]  dly_cnt_r, dly_cnt_nxt;
    logic        wait_r, wait_nxt;
    logic        start_r, start_nxt;
    logic        man_d_r, man_d_nxt;
    logic [7:0]  delay_val;
    logic        trig_pulse;
    logic        man_pulse;

    pattern_if   pif ();

    pattern_decode u_dec (
        .pif (pif.dec)
    );

    assign pif.code       = reg2_r[adc_cfg_pkg::R2_DATA_LSB +: 3];
    assign pif.frame_bits = SER_BITS_O;

    // two-stage sync on the pin, third stage only for the edge
    always_comb begin
        trig_s1_nxt = TRIGGER_PIN_I;
        trig_s2_nxt = trig_s1_r;
        trig_s3_nxt = trig_s2_r;
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else if (CLK_EN_I) begin
            trig_s1_r <= trig_s1_nxt;
            trig_s2_r <= trig_s2_nxt;
            trig_s3_r <= trig_s3_nxt;
        end
    end

    assign delay_val  = {reg3_r[adc_cfg_pkg::R3_DLY_LSB +: 2], reg2_r[adc_cfg_pkg::R2_DLY_LSB +: 6]};
    // start sources: rising edge of the synced pin, rising edge of the manual start bit
    assign trig_pulse = trig_s2_r & ~trig_s3_r;
    assign man_pulse  = reg4_r[adc_cfg_pkg::R4_MAN_BIT] & ~man_d_r;

    // register writes
    always_comb begin
        reg2_nxt  = reg2_r;
        reg3_nxt  = reg3_r;
        reg4_nxt  = reg4_r;
        man_d_nxt = reg4_r[adc_cfg_pkg::R4_MAN_BIT];
        if (WR_I) begin
            unique case (ADDR_I)
                adc_cfg_pkg::REG2_OFF: reg2_nxt = WDATA_I & adc_cfg_pkg::REG2_MASK;
                adc_cfg_pkg::REG3_OFF: reg3_nxt = WDATA_I;
                adc_cfg_pkg::REG4_OFF: reg4_nxt = WDATA_I;
                default: ;
            endcase
        end
    end

    // read data drop back to zero outside the read slot, so a stale word never looks like an answer
    always_comb begin
        rdata_nxt = 16'h0000;
        if (RD_I) begin
            unique case (ADDR_I)
                adc_cfg_pkg::REG2_OFF: rdata_nxt = reg2_r;
                adc_cfg_pkg::REG3_OFF: rdata_nxt = reg3_r;
                adc_cfg_pkg::REG4_OFF: rdata_nxt = reg4_r;
                default:               rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            reg2_r  <= adc_cfg_pkg::REG_RESET;
            reg3_r  <= adc_cfg_pkg::REG_RESET;
            reg4_r  <= adc_cfg_pkg::REG_RESET;
            man_d_r <= 1'b0;
        end else if (CLK_EN_I) begin
            reg2_r  <= reg2_nxt;
            reg3_r  <= reg3_nxt;
            reg4_r  <= reg4_nxt;
            man_d_r <= man_d_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= 16'h0000;
        end else if (CLK_EN_I) begin
            RDATA_O <= rdata_nxt;
        end
    end

    // trigger delay counter, counting sample ticks; a retrigger while waiting restarts it
    // the delay is counted in sample ticks, so it stretches with a slow sample rate, not with the core clock
    always_comb begin
        dly_cnt_nxt = dly_cnt_r;
        wait_nxt    = wait_r;
        start_nxt   = 1'b0;
        if (reg4_r[adc_cfg_pkg::R4_SSEL_BIT]) begin
            if (trig_pulse) begin
                if (delay_val == 8'h00) begin
                    start_nxt = 1'b1;
                    wait_nxt  = 1'b0;
                end else begin
                    wait_nxt    = 1'b1;
                    dly_cnt_nxt = delay_val;
                end
            end else if (wait_r && SAMPLE_TICK_I) begin
                dly_cnt_nxt = dly_cnt_r - 8'h01;
                if (dly_cnt_r == 8'h01) begin
                    wait_nxt  = 1'b0;
                    start_nxt = 1'b1;
                end
            end
        end else begin
            wait_nxt    = 1'b0;
            dly_cnt_nxt = 8'h00;
            start_nxt   = man_pulse;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dly_cnt_r <= 8'h00;
            wait_r    <= 1'b0;
            start_r   <= 1'b0;
        end else if (CLK_EN_I) begin
            dly_cnt_r <= dly_cnt_nxt;
            wait_r    <= wait_nxt;
            start_r   <= start_nxt;
        end
    end

    // decoded outputs, all registered
    logic [4:0] ser_bits_nxt, res_bits_nxt;
    logic       ser_bad_nxt, res_bad_nxt;
    logic [2:0] dpat_nxt, fpat_nxt;
    logic [4:0] prbs_len_nxt;
    logic [3:0] acc_nxt;
    logic       gain_nxt, ofs_nxt, wrsel_nxt, msb_nxt, ind_nxt, auto_nxt;
    logic       prbs_generator_enable_nxt, prbs_hold_nxt, prbs_allowed_nxt;
    logic       sync_word_nxt, ofs_start_nxt, ofs_wait_nxt;

    always_comb begin
        ser_bad_nxt = 1'b0;
        unique case (reg3_r[adc_cfg_pkg::R3_SER_LSB +: 3])
            adc_cfg_pkg::SER_12X: ser_bits_nxt = adc_cfg_pkg::BITS_12;
            adc_cfg_pkg::SER_14X: ser_bits_nxt = adc_cfg_pkg::BITS_14;
            adc_cfg_pkg::SER_16X: ser_bits_nxt = adc_cfg_pkg::BITS_16;
            adc_cfg_pkg::SER_10X: ser_bits_nxt = adc_cfg_pkg::BITS_10;
            default: begin
                // unused codes fall back to 12 and are flagged
                ser_bits_nxt = adc_cfg_pkg::BITS_12;
                ser_bad_nxt  = 1'b1;
            end
        endcase
        res_bad_nxt = 1'b0;
        unique case (reg4_r[adc_cfg_pkg::R4_RES_LSB +: 2])
            adc_cfg_pkg::RES_12: res_bits_nxt = adc_cfg_pkg::BITS_12;
            adc_cfg_pkg::RES_14: res_bits_nxt = adc_cfg_pkg::BITS_14;
            adc_cfg_pkg::RES_10: res_bits_nxt = adc_cfg_pkg::BITS_10;
            default: begin
                res_bits_nxt = adc_cfg_pkg::BITS_12;
                res_bad_nxt  = 1'b1;
            end
        endcase

        dpat_nxt         = reg2_r[adc_cfg_pkg::R2_DATA_LSB +: 3];
        fpat_nxt         = reg2_r[adc_cfg_pkg::R2_FCLK_LSB +: 3];
        sync_word_nxt    = pif.out_sync;
        // prbs only has meaning behind the custom or ramp code; the flag lets the pattern path refuse it
        prbs_allowed_nxt = pif.out_custom | pif.out_ramp;
        gain_nxt         = reg3_r[adc_cfg_pkg::R3_GAIN_BIT];
        ofs_nxt          = reg3_r[adc_cfg_pkg::R3_OFS_BIT];
        wrsel_nxt        = reg3_r[adc_cfg_pkg::R3_WRSEL_BIT];
        prbs_generator_enable_nxt      = reg4_r[adc_cfg_pkg::R4_PEN_BIT];
        prbs_hold_nxt    = reg4_r[adc_cfg_pkg::R4_PSYNC_BIT];
        prbs_len_nxt     = reg4_r[adc_cfg_pkg::R4_PMODE_BIT] ? adc_cfg_pkg::PRBS_LEN_9
                                                             : adc_cfg_pkg::PRBS_LEN_23;
        msb_nxt          = reg4_r[adc_cfg_pkg::R4_MSB_BIT];
        ind_nxt          = reg4_r[adc_cfg_pkg::R4_IND_BIT];
        auto_nxt         = reg4_r[adc_cfg_pkg::R4_SELF_BIT];
        acc_nxt          = reg4_r[adc_cfg_pkg::R4_ACC_LSB +: 4];
        // counting runs with auto mode off; only the start pulse is held back
        ofs_start_nxt    = start_r & reg4_r[adc_cfg_pkg::R4_SELF_BIT];
        ofs_wait_nxt     = wait_r;
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DATA_PATTERN_O   <= 3'h0;
            FCLK_PATTERN_O   <= 3'h0;
            SER_BITS_O       <= adc_cfg_pkg::BITS_12;
            SER_CODE_BAD_O   <= 1'b0;
            RES_BITS_O       <= adc_cfg_pkg::BITS_12;
            RES_CODE_BAD_O   <= 1'b0;
            DIGITAL_GAIN_ENABLE_O    <= 1'b0;
            DIG_OFS_EN_O     <= 1'b0;
            LINK_WR_SEL_O    <= 1'b0;
            PRBS_GENERATOR_ENABLE_O        <= 1'b0;
            PRBS_HOLD_O      <= 1'b0;
            PRBS_LEN_O       <= adc_cfg_pkg::PRBS_LEN_23;
            PRBS_ALLOWED_O   <= 1'b0;
            MSB_FIRST_O      <= 1'b0;
            IND_PATTERNS_O   <= 1'b0;
            AUTO_OFS_EN_O    <= 1'b0;
            ACC_SAMPLES_O    <= 4'h0;
            DATA_SYNC_WORD_O <= 1'b0;
            OFS_START_O      <= 1'b0;
            OFS_WAIT_O       <= 1'b0;
        end else if (CLK_EN_I) begin
            DATA_PATTERN_O   <= dpat_nxt;
            FCLK_PATTERN_O   <= fpat_nxt;
            SER_BITS_O       <= ser_bits_nxt;
            SER_CODE_BAD_O   <= ser_bad_nxt;
            RES_BITS_O       <= res_bits_nxt;
            RES_CODE_BAD_O   <= res_bad_nxt;
            DIGITAL_GAIN_ENABLE_O    <= gain_nxt;
            DIG_OFS_EN_O     <= ofs_nxt;
            LINK_WR_SEL_O    <= wrsel_nxt;
            PRBS_GENERATOR_ENABLE_O        <= prbs_generator_enable_nxt;
            PRBS_HOLD_O      <= prbs_hold_nxt;
            PRBS_LEN_O       <= prbs_len_nxt;
            PRBS_ALLOWED_O   <= prbs_allowed_nxt;
            MSB_FIRST_O      <= msb_nxt;
            IND_PATTERNS_O   <= ind_nxt;
            AUTO_OFS_EN_O    <= auto_nxt;
            ACC_SAMPLES_O    <= acc_nxt;
            DATA_SYNC_WORD_O <= sync_word_nxt;
            OFS_START_O      <= ofs_start_nxt;
            OFS_WAIT_O       <= ofs_wait_nxt;
        end
    end
endmodule // adc_output_pattern_config_regs

//--- core/pattern_decode.sv
// decoder of the common 3-bit test-pattern code
`timescale 1ns/1ps
module pattern_decode (
    pattern_if.dec pif
);
    always_comb begin
        pif.out_normal = 1'b0;
        pif.out_sync   = 1'b0;
        pif.out_deskew = 1'b0;
        pif.out_custom = 1'b0;
        pif.out_ones   = 1'b0;
        pif.out_toggle = 1'b0;
        pif.out_zeros  = 1'b0;
        pif.out_ramp   = 1'b0;
        unique case (adc_cfg_pkg::pattern_t'(pif.code))
            adc_cfg_pkg::PAT_NORMAL: pif.out_normal = 1'b1;
            adc_cfg_pkg::PAT_SYNC:   pif.out_sync   = 1'b1;
            adc_cfg_pkg::PAT_DESKEW: pif.out_deskew = 1'b1;
            adc_cfg_pkg::PAT_CUSTOM: pif.out_custom = 1'b1;
            adc_cfg_pkg::PAT_ONES:   pif.out_ones   = 1'b1;
            adc_cfg_pkg::PAT_TOGGLE: pif.out_toggle = 1'b1;
            adc_cfg_pkg::PAT_ZEROS:  pif.out_zeros  = 1'b1;
            adc_cfg_pkg::PAT_RAMP:   pif.out_ramp   = 1'b1;
        endcase
    end
endmodule // pattern_decode

//--- core/pattern_if.sv
// carrier between the config bank and its pattern decoder
`timescale 1ns/1ps
interface pattern_if;
    logic [2:0] code;
    logic [4:0] frame_bits;
    logic       out_ones;
    logic       out_zeros;
    logic       out_sync;
    logic       out_deskew;
    logic       out_custom;
    logic       out_toggle;
    logic       out_ramp;
    logic       out_normal;
    modport cfg (output code, input out_ones, out_zeros, out_sync, out_deskew, out_custom, out_toggle, out_ramp,
                 out_normal, output frame_bits);
    modport dec (input code, frame_bits, output out_ones, out_zeros, out_sync, out_deskew, out_custom, out_toggle,
                 out_ramp, out_normal);
endinterface

//--- tb/adc_cfg_properties.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module adc_cfg_properties (
    // clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        NRST_I,
    input wire logic        CLK_EN_I,
    // register port
    input wire logic [7:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    // decoded outputs
    input wire logic [2:0]  DATA_PATTERN_O,
    input wire logic [2:0]  FCLK_PATTERN_O,
    input wire logic [4:0]  SER_BITS_O,
    input wire logic        SER_CODE_BAD_O,
    input wire logic        DIGITAL_GAIN_ENABLE_O,
    input wire logic        DIG_OFS_EN_O,
    input wire logic [4:0]  PRBS_LEN_O,
    input wire logic        AUTO_OFS_EN_O,
    input wire logic        OFS_START_O,
    input wire logic        OFS_WAIT_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I || !CLK_EN_I);

    property p_rdata_idle;
        !$past(RD_I) |-> RDATA_O == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_gain;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG3_OFF |-> DIGITAL_GAIN_ENABLE_O == $past(WDATA_I[12], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain enable not following write");
    property p_ofs;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG3_OFF |-> DIG_OFS_EN_O == $past(WDATA_I[8], 2);
    endproperty
    a_ofs: assert property (p_ofs) else $error("offset enable not following write");
    property p_data_pat;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG2_OFF |-> DATA_PATTERN_O == $past(WDATA_I[9:7], 2);
    endproperty
    a_data_pat: assert property (p_data_pat) else $error("data pattern not following write");
    property p_fclk_pat;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG2_OFF |-> FCLK_PATTERN_O == $past(WDATA_I[15:13], 2);
    endproperty
    a_fclk_pat: assert property (p_fclk_pat) else $error("frame pattern not following write");
    property p_prbs_len;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG4_OFF |->
            PRBS_LEN_O == ($past(WDATA_I[6], 2) ? adc_cfg_pkg::PRBS_LEN_9 : adc_cfg_pkg::PRBS_LEN_23);
    endproperty
    a_prbs_len: assert property (p_prbs_len) else $error("prbs length wrong");
    property p_ser_rate;
        $past(WR_I, 2) && $past(ADDR_I, 2) == adc_cfg_pkg::REG3_OFF && $past(WDATA_I[15:13], 2) == adc_cfg_pkg::SER_10X
            |-> SER_BITS_O == adc_cfg_pkg::BITS_10 && !SER_CODE_BAD_O;
    endproperty
    a_ser_rate: assert property (p_ser_rate) else $error("serialization width not following rate code");
    property p_start_one;
        OFS_START_O |=> !OFS_START_O;
    endproperty
    a_start_one: assert property (p_start_one) else $error("start pulse longer than one cycle");
    property p_wait_end;
        $fell(OFS_WAIT_O) && AUTO_OFS_EN_O |-> OFS_START_O;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("wait ended without start");
endmodule // adc_cfg_properties

//--- tb/adc_output_pattern_config_regs_test.sv
// self-checking bench for the output pattern configuration bank
`timescale 1ns/1ps
module adc_output_pattern_config_regs_test;
    logic clk, nrst, cen, wr, rd, tick, trig;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [2:0] dpat, fpat;
    logic [4:0] ser_bits, res_bits, prbs_len;
    logic [3:0] acc;
    logic ser_bad, res_bad, gain, ofs, wsel, pen, phold, pallow, msb, ind, auto, sync, start, waiting;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    adc_output_pattern_config_regs i_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(cen), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SAMPLE_TICK_I(tick), .TRIGGER_PIN_I(trig),
        .DATA_PATTERN_O(dpat), .FCLK_PATTERN_O(fpat), .SER_BITS_O(ser_bits), .SER_CODE_BAD_O(ser_bad),
        .RES_BITS_O(res_bits), .RES_CODE_BAD_O(res_bad), .DIGITAL_GAIN_ENABLE_O(gain), .DIG_OFS_EN_O(ofs),
        .LINK_WR_SEL_O(wsel), .PRBS_GENERATOR_ENABLE_O(pen), .PRBS_HOLD_O(phold), .PRBS_LEN_O(prbs_len),
        .PRBS_ALLOWED_O(pallow), .MSB_FIRST_O(msb), .IND_PATTERNS_O(ind), .AUTO_OFS_EN_O(auto),
        .ACC_SAMPLES_O(acc), .DATA_SYNC_WORD_O(sync), .OFS_START_O(start), .OFS_WAIT_O(waiting));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp, "read data");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic test_reset_rw();
        rd_chk(8'h03, 16'h0000);
        rd_chk(8'h04, 16'h0000);
        chk({ser_bits, res_bits, prbs_len}, {5'h0C, 5'h0C, 5'h17}, "reset outputs");
        wr_reg(8'h03, 16'h9700);
        rd_chk(8'h03, 16'h9700);
        wr_reg(8'h04, 16'hA5C3);
        rd_chk(8'h04, 16'hA5C3);
        chk({auto, acc, ind}, {1'b1, 4'h2, 1'b1}, "register 4 side fields");
        wr_reg(8'h05, 16'hFFFF);
        rd_chk(8'h05, 16'h0000);
        $display("test reset and readback done");
    endtask

    task automatic test_freeze();
        @(posedge clk) cen <= 1'b0;
        wr_reg(8'h03, 16'h3100);
        @(posedge clk) cen <= 1'b1;
        rd_chk(8'h03, 16'h9700);
        chk(ser_bits, 5'h10, "frozen rate");
        $display("test clock enable done");
    endtask

    task automatic test_patterns();
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'h02, 16'(c << 13 | c << 7));
            chk({dpat, fpat, sync, pallow}, {3'(c), 3'(c), c == 1, c == 3 || c == 7}, "pattern");
        end
        $display("test patterns done");
    endtask

    task automatic test_rate();
        logic [2:0] c;
        logic [4:0] eb;
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : (i == 2) ? 3'h3 : 3'h4;
            eb = (i == 0) ? 5'h0C : (i == 1) ? 5'h0E : (i == 2) ? 5'h0A : 5'h10;
            wr_reg(8'h03, {c, 1'(i), 3'h0, 1'(i >> 1), 2'h0, 1'(i ^ (i >> 1)), 5'h00});
            chk({ser_bits, ser_bad, gain, ofs, wsel}, {eb, 1'b0, 1'(i), 1'(i >> 1), 1'(i ^ (i >> 1))},
                "rate and enables");
        end
        $display("test rate done");
    endtask

    task automatic test_res();
        logic [4:0] eb;
        for (int c = 0; c < 4; c++) begin
            eb = (c == 1) ? 5'h0E : (c == 3) ? 5'h0A : 5'h0C;
            wr_reg(8'h04, 16'(c | (c & 1) << 6 | (c >> 1) << 4 | (c & 1) << 5 | (c >> 1) << 7));
            chk({res_bits, res_bad, prbs_len, msb, pen, phold}, {eb, c == 2, (c & 1) ? 5'h09 : 5'h17,
                1'(c >> 1), 1'(c), 1'(c >> 1)}, "resolution and prbs");
        end
        $display("test resolution done");
    endtask

    task automatic test_trigger();
        int n;
        bit seen;
        n = 0;
        seen = 0;
        wr_reg(8'h02, 16'h0002);
        wr_reg(8'h03, 16'h0200);
        wr_reg(8'h04, 16'hC000);
        @(posedge clk) trig <= 1'b1;
        repeat (3) @(posedge clk);
        trig <= 1'b0;
        repeat (6) @(negedge clk);
        chk(waiting, 1'b1, "wait level");
        while (!seen && n < 300) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
            n++;
            repeat (3) @(negedge clk) if (start) seen = 1;
        end
        chk(16'(n), 16'h0042, "ticks before start");
        $display("test trigger done");
    endtask

    task automatic test_manual();
        bit seen;
        seen = 0;
        wr_reg(8'h04, 16'h0000);
        wr_reg(8'h04, 16'h2000);
        repeat (4) @(negedge clk) if (start) seen = 1;
        chk(seen, 1'b0, "start with auto mode off");
        wr_reg(8'h04, 16'h8000);
        @(posedge clk) begin
            wr <= 1'b1; addr <= 8'h04; wdata <= 16'hA000;
        end
        @(posedge clk) wr <= 1'b0;
        repeat (5) @(negedge clk) if (start) seen = 1;
        chk(seen, 1'b1, "manual start");
        $display("test manual start done");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        nrst = 1'b0; cen = 1'b1; wr = 1'b0; rd = 1'b0; tick = 1'b0; trig = 1'b0; addr = 8'h00; wdata = 16'h0000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        test_reset_rw();
        test_freeze();
        test_patterns();
        test_rate();
        test_res();
        test_trigger();
        test_manual();
        final_report();
    end
endmodule // adc_output_pattern_config_regs_test

bind adc_output_pattern_config_regs adc_cfg_properties u_props (.CORE_CLK_I, .NRST_I, .CLK_EN_I, .ADDR_I, .WDATA_I, .WR_I,
    .RD_I, .RDATA_O, .DATA_PATTERN_O, .FCLK_PATTERN_O, .SER_BITS_O, .SER_CODE_BAD_O, .DIGITAL_GAIN_ENABLE_O,
    .DIG_OFS_EN_O, .PRBS_LEN_O, .AUTO_OFS_EN_O, .OFS_START_O, .OFS_WAIT_O);
